// *** rtl/sra_core.sv ***
// Serial register access front end with interrupt flag logic.
`timescale 1ns/100ps
`default_nettype none

module sra_core
   import sra_pkg::*;
#(
   parameter logic [15:0] DEVICE_ID = 16'h5aa5  // Arbitrary identity value.
) (
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          spi_sclk,
   input  wire logic          spi_cs_n,
   input  wire logic          spi_mosi,
   output logic               spi_miso_out,
   output logic               spi_miso_oe,
   input  wire logic [19:0]   dac_port_mask,
   input  wire logic [19:0]   adc_port_mask,
   input  wire logic          adc_conv_done,
   input  wire logic          adc_sweep_done,
   input  wire logic [19:0]   adc_refresh,
   input  wire logic [239:0]  adc_data,
   input  wire logic [19:0]   gpi_in,
   input  wire logic [19:0]   overload_in,
   input  wire logic [2:0]    die_temp_alarm,
   input  wire logic [2:0]    remote_temp1_alarm,
   input  wire logic [2:0]    remote_temp2_alarm,
   input  wire logic          io_supply_low,
   input  wire logic [11:0]   temp_int_data,
   input  wire logic [11:0]   temp_ext1_data,
   input  wire logic [11:0]   temp_ext2_data,
   output logic [19:0]        gpo_out,
   output logic [15:0]        dev_ctl,
   output logic               dac_wr,
   output logic [4:0]         dac_wr_port,
   output logic [15:0]        dac_wr_data,
   output logic               irq_n
);

   typedef struct packed {
      sra_lnk_phase_t phase;
      logic [3:0]     cnt;
      logic [14:0]    sh;
   } sra_frame_t;

   typedef struct packed {
      logic [7:0]     hdr;
      logic [15:0]    wdata;
      logic           first;
      logic           tgl;
   } sra_hold_t;

   typedef struct packed {
      logic [14:0]    sh;
      logic           bit_q;
   } sra_tx_t;

   typedef struct packed {
      logic [2:0]     tg;
      logic           seen;
      logic [6:0]     ptr;
      logic           rd;
      logic [15:0]    rd_word;
      logic [19:0]    g1;
      logic [19:0]    g2;
      logic [19:0]    g3;
      logic [19:0]    glvl;
      logic [2:0]     vs;
      logic           vlvl;
      logic [15:0]    flags;
      logic [15:0]    mask;
      logic [15:0]    devctl;
      logic [39:0]    gmode;
      logic [19:0]    adc_st;
      logic [19:0]    oc_st;
      logic [19:0]    gpi_st;
      logic [19:0]    unread;
      logic [19:0]    gpo;
      logic [2:0]     arm;
      logic [2:0]     seen_lo;
      logic [2:0]     seen_hi;
      logic           irq_n;
      logic           dac_wr;
      logic [4:0]     dac_port;
      logic [15:0]    dac_data;
   } sra_core_t;

   sra_frame_t  f_reg;
   sra_frame_t  f_next;
   sra_hold_t   h_reg;
   sra_hold_t   h_next;
   sra_tx_t     t_reg;
   sra_tx_t     t_next;
   sra_core_t   c_reg;
   sra_core_t   c_next;
   logic        frame_rst;
   logic [19:0] gpi_edge;
   logic [19:0] gpi_agree;

   assign frame_rst = sys_rst | spi_cs_n;

   // ---------------- Link side, on the serial clock ----------------

   always_comb begin
      f_next = f_reg;
      h_next = h_reg;
      f_next.sh = {f_reg.sh[13:0], spi_mosi};
      f_next.cnt = f_reg.cnt + 4'h1;
      if (f_reg.phase == LNK_HDR) begin
         if (f_reg.cnt == HDR_LAST) begin
            h_next.hdr = {f_reg.sh[6:0], spi_mosi};
            h_next.first = 1'b1;
            h_next.tgl = ~h_reg.tgl;
            f_next.phase = LNK_DATA;
            f_next.cnt = '0;
         end
      end else if (f_reg.cnt == WORD_LAST) begin
         // The word is handed over only when complete.
         h_next.wdata = {f_reg.sh, spi_mosi};
         h_next.first = 1'b0;
         h_next.tgl = ~h_reg.tgl;
      end
   end

   // Bit position resets whenever chip select is high.
   always_ff @(posedge spi_sclk or posedge frame_rst) begin
      if (frame_rst) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end

   always_ff @(posedge spi_sclk or posedge sys_rst) begin
      if (sys_rst) begin
         h_reg <= '0;
      end else begin
         h_reg <= h_next;
      end
   end

   // The word to send was fetched by the system side within a few cycles of
   // the rising edge that ended the previous byte or word, so it is stable
   // well before this falling edge loads it.
   always_comb begin
      t_next.bit_q = t_reg.sh[14];
      t_next.sh = {t_reg.sh[13:0], 1'b0};
      if (f_reg.phase == LNK_DATA && f_reg.cnt == '0) begin
         t_next.bit_q = c_reg.rd & c_reg.rd_word[15];
         t_next.sh = c_reg.rd ? c_reg.rd_word[14:0] : '0;
      end
   end

   always_ff @(negedge spi_sclk or posedge frame_rst) begin
      if (frame_rst) begin
         t_reg <= '0;
      end else begin
         t_reg <= t_next;
      end
   end

   assign spi_miso_out = t_reg.bit_q;
   assign spi_miso_oe = ~spi_cs_n;

   // ---------------- System side, on clk ----------------

   function automatic logic [4:0] next_port(input logic [19:0] m,
                                            input logic [4:0]  p);
      logic [4:0] r;
      int         k;
      int         idx;
      r = p;
      for (k = NPORT; k >= 1; k--) begin
         idx = (int'(p) + k) % NPORT;
         if (m[idx]) begin
            r = 5'(idx);
         end
      end
      return r;
   endfunction

   function automatic logic in_adc(input logic [6:0] a);
      return a >= A_ADC_BASE && a <= A_ADC_END;
   endfunction

   function automatic logic in_dac(input logic [6:0] a);
      return a >= A_DAC_BASE && a <= A_DAC_END;
   endfunction

   function automatic logic [6:0] next_addr(input logic [6:0] a,
                                            input logic       wr);
      logic [6:0] r;
      r = (a == A_LAST) ? a : a + 7'h01;
      if (c_reg.devctl[CTL_CTX]) begin
         if (wr && in_dac(a)) begin
            r = A_DAC_BASE
                + 7'(next_port(dac_port_mask, 5'(a - A_DAC_BASE)));
         end else if (!wr && in_adc(a)) begin
            r = A_ADC_BASE
                + 7'(next_port(adc_port_mask, 5'(a - A_ADC_BASE)));
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] rd_mux(input logic [6:0] a);
      logic [15:0] r;
      logic [4:0]  p;
      r = '0;
      p = 5'(a - A_ADC_BASE);
      case (a)
         A_ID:       r = DEVICE_ID;
         A_INT:      r = c_reg.flags;
         A_ADCST_LO: r = c_reg.adc_st[15:0];
         A_ADCST_HI: r = 16'(c_reg.adc_st[19:16]);
         A_OCST_LO:  r = c_reg.oc_st[15:0];
         A_OCST_HI:  r = 16'(c_reg.oc_st[19:16]);
         A_GPIST_LO: r = c_reg.gpi_st[15:0];
         A_GPIST_HI: r = 16'(c_reg.gpi_st[19:16]);
         A_TMP_INT:  r = 16'(temp_int_data);
         A_TMP_EXT1: r = 16'(temp_ext1_data);
         A_TMP_EXT2: r = 16'(temp_ext2_data);
         A_GPI_LO:   r = c_reg.glvl[15:0];
         A_GPI_HI:   r = 16'(c_reg.glvl[19:16]);
         A_GPO_LO:   r = c_reg.gpo[15:0];
         A_GPO_HI:   r = 16'(c_reg.gpo[19:16]);
         A_CTL:      r = c_reg.devctl;
         A_MASK:     r = c_reg.mask;
         A_GMODE0:   r = c_reg.gmode[15:0];
         A_GMODE1:   r = c_reg.gmode[31:16];
         A_GMODE2:   r = 16'(c_reg.gmode[39:32]);
         default: begin
            if (in_adc(a)) begin
               r = 16'(adc_data[int'(p) * ADC_W +: ADC_W]);
            end
         end
      endcase
      return r;
   endfunction

   // Edge detection works on the filtered level of each input port.
   genvar gi;
   generate
      for (gi = 0; gi < NPORT; gi++) begin : g_port
         logic [1:0] sel;
         logic       rise;
         logic       fall;
         assign gpi_agree[gi] = c_reg.g2[gi] == c_reg.g3[gi];
         assign sel = c_reg.gmode[2 * gi +: 2];
         assign rise = gpi_agree[gi] & c_reg.g3[gi] & ~c_reg.glvl[gi];
         assign fall = gpi_agree[gi] & ~c_reg.g3[gi] & c_reg.glvl[gi];
         assign gpi_edge[gi] = (sel == GM_RISE && rise)
                               || (sel == GM_FALL && fall)
                               || (sel == GM_BOTH && (rise || fall));
      end
   endgenerate

   always_comb begin
      logic        ev;
      logic [6:0]  pa;
      logic [15:0] set;
      logic [15:0] clr;
      logic [19:0] adc_clr;
      logic [19:0] oc_clr;
      logic [19:0] gpi_clr;
      logic [19:0] unread_clr;
      logic [15:0] snap;
      logic [4:0]  port;
      int          s;
      ev = 1'b0;
      pa = '0;
      set = '0;
      clr = '0;
      adc_clr = '0;
      oc_clr = '0;
      gpi_clr = '0;
      unread_clr = '0;
      snap = c_reg.rd_word;
      port = 5'(c_reg.ptr - A_ADC_BASE);
      s = 0;
      c_next = c_reg;
      c_next.dac_wr = 1'b0;

      c_next.tg = {c_reg.tg[1:0], h_reg.tgl};
      ev = (c_reg.tg[1] == c_reg.tg[2]) && (c_reg.tg[2] != c_reg.seen);
      c_next.g1 = gpi_in;
      c_next.g2 = c_reg.g1;
      c_next.g3 = c_reg.g2;
      c_next.glvl = (c_reg.g3 & gpi_agree) | (c_reg.glvl & ~gpi_agree);
      c_next.vs = {c_reg.vs[1:0], io_supply_low};
      if (c_reg.vs[1] == c_reg.vs[2]) begin
         c_next.vlvl = c_reg.vs[2];
      end

      if (ev) begin
         c_next.seen = c_reg.tg[2];
         if (h_reg.first) begin
            pa = h_reg.hdr[7:1];
            c_next.rd = h_reg.hdr[0];
         end else begin
            pa = next_addr(c_reg.ptr, !c_reg.rd);
            if (c_reg.rd) begin
               // The word just sent completes its read now.
               case (c_reg.ptr)
                  A_INT: begin
                     clr = snap & INT_RD_CLR;
                     c_next.arm = '1;
                     c_next.seen_lo = '0;
                     c_next.seen_hi = '0;
                  end
                  A_ADCST_LO: begin
                     adc_clr[15:0] = snap;
                     c_next.seen_lo[0] = c_reg.arm[0];
                  end
                  A_ADCST_HI: begin
                     adc_clr[19:16] = snap[3:0];
                     c_next.seen_hi[0] = c_reg.arm[0];
                  end
                  A_GPIST_LO: begin
                     gpi_clr[15:0] = snap;
                     c_next.seen_lo[1] = c_reg.arm[1];
                  end
                  A_GPIST_HI: begin
                     gpi_clr[19:16] = snap[3:0];
                     c_next.seen_hi[1] = c_reg.arm[1];
                  end
                  A_OCST_LO: begin
                     oc_clr[15:0] = snap;
                     c_next.seen_lo[2] = c_reg.arm[2];
                  end
                  A_OCST_HI: begin
                     oc_clr[19:16] = snap[3:0];
                     c_next.seen_hi[2] = c_reg.arm[2];
                  end
                  default: begin
                     if (in_adc(c_reg.ptr)) begin
                        unread_clr[port] = 1'b1;
                     end
                  end
               endcase
            end else begin
               case (c_reg.ptr)
                  A_GPO_LO: c_next.gpo[15:0] = h_reg.wdata;
                  A_GPO_HI: c_next.gpo[19:16] = h_reg.wdata[3:0];
                  A_CTL:    c_next.devctl = h_reg.wdata;
                  A_MASK:   c_next.mask = h_reg.wdata;
                  A_GMODE0: c_next.gmode[15:0] = h_reg.wdata;
                  A_GMODE1: c_next.gmode[31:16] = h_reg.wdata;
                  A_GMODE2: c_next.gmode[39:32] = h_reg.wdata[7:0];
                  default: begin
                     if (in_dac(c_reg.ptr)) begin
                        c_next.dac_wr = 1'b1;
                        c_next.dac_port = 5'(c_reg.ptr - A_DAC_BASE);
                        c_next.dac_data = h_reg.wdata;
                     end
                  end
               endcase
            end
         end
         c_next.ptr = pa;
         c_next.rd_word = rd_mux(pa);
      end

      // A three-read clear finishes once both status halves were read.
      for (s = 0; s < 3; s++) begin
         if (c_next.arm[s] && c_next.seen_lo[s] && c_next.seen_hi[s]) begin
            c_next.arm[s] = 1'b0;
            case (s)
               0: clr[B_SRDY] = 1'b1;
               1: begin
                  clr[B_EDGE] = 1'b1;
                  clr[B_EOVR] = 1'b1;
               end
               default: clr[B_OVL] = 1'b1;
            endcase
         end
      end

      case (c_reg.devctl[CTL_ADC_MODE +: 2])
         ADC_CONV: set[B_CDONE] = adc_conv_done;
         ADC_SWEEP, ADC_CONT: set[B_CDONE] = adc_sweep_done;
         default: set[B_CDONE] = 1'b0;
      endcase
      set[B_SRDY] = |adc_refresh;
      set[B_SOVW] = |(adc_refresh & c_reg.unread & ~unread_clr);
      set[B_EDGE] = |gpi_edge;
      set[B_EOVR] = |(gpi_edge & c_reg.gpi_st & ~gpi_clr);
      set[B_OVL] = |(overload_in & dac_port_mask);
      set[B_TINT +: 3] = die_temp_alarm;
      set[B_TEXT1 +: 3] = remote_temp1_alarm;
      set[B_TEXT2 +: 3] = remote_temp2_alarm;
      set[B_IO_SUPPLY_LOW_FLAG] = c_reg.vlvl;

      c_next.flags = (c_reg.flags & ~clr) | set;
      c_next.adc_st = (c_reg.adc_st & ~adc_clr) | adc_refresh;
      c_next.oc_st = (c_reg.oc_st & ~oc_clr)
                     | (overload_in & dac_port_mask);
      c_next.gpi_st = (c_reg.gpi_st & ~gpi_clr) | gpi_edge;
      c_next.unread = (c_reg.unread & ~unread_clr) | adc_refresh;
      c_next.irq_n = ~|(c_reg.flags & ~c_reg.mask);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         c_reg <= '0;
         c_reg.mask <= MASK_RST;
         c_reg.irq_n <= 1'b1;
      end else begin
         c_reg <= c_next;
      end
   end

   assign gpo_out = c_reg.gpo;
   assign dev_ctl = c_reg.devctl;
   assign dac_wr = c_reg.dac_wr;
   assign dac_wr_port = c_reg.dac_port;
   assign dac_wr_data = c_reg.dac_data;
   assign irq_n = c_reg.irq_n;

endmodule

`default_nettype wire

// *** rtl/sra_pkg.sv ***
// Constants and types shared by the serial register access block.
package sra_pkg;

   localparam int NPORT = 20;

   // Register addresses of the seven-bit map.
   localparam logic [6:0] A_ID       = 7'h00;
   localparam logic [6:0] A_INT      = 7'h01;
   localparam logic [6:0] A_ADCST_LO = 7'h02;
   localparam logic [6:0] A_ADCST_HI = 7'h03;
   localparam logic [6:0] A_OCST_LO  = 7'h04;
   localparam logic [6:0] A_OCST_HI  = 7'h05;
   localparam logic [6:0] A_GPIST_LO = 7'h06;
   localparam logic [6:0] A_GPIST_HI = 7'h07;
   localparam logic [6:0] A_TMP_INT  = 7'h08;
   localparam logic [6:0] A_TMP_EXT1 = 7'h09;
   localparam logic [6:0] A_TMP_EXT2 = 7'h0a;
   localparam logic [6:0] A_GPI_LO   = 7'h0b;
   localparam logic [6:0] A_GPI_HI   = 7'h0c;
   localparam logic [6:0] A_GPO_LO   = 7'h0d;
   localparam logic [6:0] A_GPO_HI   = 7'h0e;
   localparam logic [6:0] A_CTL      = 7'h10;
   localparam logic [6:0] A_MASK     = 7'h11;
   localparam logic [6:0] A_GMODE0   = 7'h12;
   localparam logic [6:0] A_GMODE1   = 7'h13;
   localparam logic [6:0] A_GMODE2   = 7'h14;
   localparam logic [6:0] A_ADC_BASE = 7'h40;
   localparam logic [6:0] A_ADC_END  = 7'h53;
   localparam logic [6:0] A_DAC_BASE = 7'h60;
   localparam logic [6:0] A_DAC_END  = 7'h73;
   localparam logic [6:0] A_LAST     = 7'h73;

   // Interrupt register bit positions.
   localparam int B_CDONE = 0;
   localparam int B_SRDY  = 1;
   localparam int B_SOVW  = 2;
   localparam int B_EDGE  = 3;
   localparam int B_EOVR  = 4;
   localparam int B_OVL   = 5;
   localparam int B_TINT  = 6;
   localparam int B_TEXT1 = 9;
   localparam int B_TEXT2 = 12;
   localparam int B_IO_SUPPLY_LOW_FLAG  = 15;
   // Bits cleared by a plain read of the interrupt register.
   localparam logic [15:0] INT_RD_CLR = 16'hffc5;
   localparam logic [15:0] MASK_RST   = 16'hffff;

   // Device control fields.
   localparam int CTL_CTX = 14;
   localparam int CTL_ADC_MODE = 0;
   localparam logic [1:0] ADC_IDLE  = 2'h0;
   localparam logic [1:0] ADC_SWEEP = 2'h1;
   localparam logic [1:0] ADC_CONV  = 2'h2;
   localparam logic [1:0] ADC_CONT  = 2'h3;

   // Edge selection per input port.
   localparam logic [1:0] GM_NONE = 2'h0;
   localparam logic [1:0] GM_RISE = 2'h1;
   localparam logic [1:0] GM_FALL = 2'h2;
   localparam logic [1:0] GM_BOTH = 2'h3;

   localparam logic [3:0] HDR_LAST  = 4'h7;
   localparam logic [3:0] WORD_LAST = 4'hf;
   localparam int ADC_W = 12;

   typedef enum logic {LNK_HDR, LNK_DATA} sra_lnk_phase_t;

endpackage

// *** verification/sra_checker.sv ***
// Port-level assertions for the serial register access block.
`timescale 1ns/100ps
`default_nettype none
module sra_checker (
   input wire logic         clk,
   input wire logic         sys_rst,
   input wire logic         spi_sclk,
   input wire logic         spi_cs_n,
   input wire logic         spi_miso_out,
   input wire logic         spi_miso_oe,
   input wire logic [19:0]  gpo_out,
   input wire logic [15:0]  dev_ctl,
   input wire logic         dac_wr,
   input wire logic [4:0]   dac_wr_port,
   input wire logic         irq_n
);
   logic [3:0] hdr_cnt;
   // Counts command bits of the frame, saturating once the byte is in.
   always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
      if (spi_cs_n)
         hdr_cnt <= 4'h0;
      else if (hdr_cnt != 4'h8)
         hdr_cnt <= hdr_cnt + 4'h1;
   end
   a_oe_tracks_cs: assert property (
      @(posedge clk) disable iff (sys_rst) spi_miso_oe == !spi_cs_n)
      else $error("miso enable differs from select");
   a_hdr_miso_low: assert property (
      @(posedge spi_sclk) disable iff (spi_cs_n)
      hdr_cnt < 4'h8 |-> spi_miso_out == 1'h0)
      else $error("miso not low during command byte");
   a_miso_on_fall: assert property (
      @(posedge clk) disable iff (sys_rst)
      $changed(spi_miso_out) |-> !spi_sclk)
      else $error("miso changed while serial clock high");
   a_dac_one_cycle: assert property (
      @(posedge clk) disable iff (sys_rst) dac_wr |=> !dac_wr)
      else $error("output data strobe longer than one cycle");
   a_dac_port_map: assert property (
      @(posedge clk) disable iff (sys_rst) dac_wr |-> dac_wr_port <= 5'h13)
      else $error("output data strobe for port beyond map");
   a_write_in_frame: assert property (
      @(posedge clk) disable iff (sys_rst)
      ($changed(gpo_out) || $changed(dev_ctl) || dac_wr) |-> !spi_cs_n)
      else $error("register changed outside a frame");
   a_irq_reset_quiet: assert property (
      @(posedge clk) disable iff (sys_rst) $fell(sys_rst) |-> irq_n[*8])
      else $error("interrupt asserted while masked after reset");
   a_irq_rise_frame: assert property (
      @(posedge clk) disable iff (sys_rst) $rose(irq_n) |-> !spi_cs_n)
      else $error("interrupt released without a clearing access");
endmodule
bind sra_core sra_checker chk_i (.clk, .sys_rst, .spi_sclk, .spi_cs_n,
   .spi_miso_out, .spi_miso_oe, .gpo_out, .dev_ctl, .dac_wr, .dac_wr_port,
   .irq_n);
`default_nettype wire

// *** verification/sra_host.sv ***
// Behavioural serial host that frames register accesses in clock mode 0.
`timescale 1ns/100ps
`default_nettype none
module sra_host (
   output logic       spi_sclk,
   output logic       spi_cs_n,
   output logic       spi_mosi,
   input  wire logic  spi_miso_out,
   input  wire logic  spi_miso_oe
);
   logic [15:0] wr_q [8];
   logic [15:0] rd_q [8];
   logic        smp;
   initial begin
      spi_sclk = 1'h0;
      spi_cs_n = 1'h1;
      spi_mosi = 1'h1;
   end
   // Data is set while the clock is low and read back on the rising edge.
   task automatic shift(input logic d);
      spi_mosi = d;
      #40 spi_sclk = 1'h1;
      smp = spi_miso_oe ? spi_miso_out : 1'hx;
      #40 spi_sclk = 1'h0;
   endtask
   // The clock stands low outside a frame and the data line idles inverted.
   task automatic frame(input logic [6:0] a, input logic rw, input int n);
      logic [7:0] cmd;
      cmd = {a, rw};
      #13.3 spi_cs_n = 1'h0;
      for (int b = 7; b >= 0; b--) shift(cmd[b]);
      for (int k = 0; k < n; k++)
         for (int b = 15; b >= 0; b--) begin
            shift(wr_q[k][b]);
            rd_q[k][b] = smp;
         end
      #40 spi_cs_n = 1'h1;
      spi_mosi = ~spi_mosi;
      #60;
   endtask
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the serial register access block.
`timescale 1ns/100ps
`default_nettype none
module testbench
   import sra_pkg::*;
;
   localparam logic [15:0] ID_V = 16'h3c69;  // Arbitrary identity value.
   logic          clk, sys_rst, adc_conv_done, adc_sweep_done, io_supply_low;
   logic          spi_sclk, spi_cs_n, spi_mosi, spi_miso_out, spi_miso_oe;
   logic          dac_wr, irq_n;
   logic [2:0]    die_temp_alarm, remote_temp1_alarm, remote_temp2_alarm;
   logic [11:0]   temp_int_data, temp_ext1_data, temp_ext2_data;
   logic [19:0]   dac_port_mask, adc_port_mask, adc_refresh, gpi_in;
   logic [19:0]   overload_in, gpo_out;
   logic [239:0]  adc_data;
   logic [15:0]   dev_ctl, dac_wr_data;
   logic [4:0]    dac_wr_port, p;
   logic [31:0]   v;
   logic [20:0]   wq[$];
   int            n_fail, n_tests, cyc;
   sra_core #(.DEVICE_ID(ID_V)) uut (
      .clk, .sys_rst, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso_out,
      .spi_miso_oe, .dac_port_mask, .adc_port_mask, .adc_conv_done,
      .adc_sweep_done, .adc_refresh, .adc_data, .gpi_in, .overload_in,
      .die_temp_alarm, .remote_temp1_alarm, .remote_temp2_alarm,
      .io_supply_low, .temp_int_data, .temp_ext1_data, .temp_ext2_data,
      .gpo_out, .dev_ctl, .dac_wr, .dac_wr_port, .dac_wr_data, .irq_n);
   sra_host host (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso_out,
                  .spi_miso_oe);
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) if (dac_wr === 1'h1)
      wq.push_back({dac_wr_port, dac_wr_data});
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         n_fail++;
         end_of_test();
      end
   end
   // Next port set in the mask after q, wrapping past the top port.
   function automatic logic [4:0] nxt(input logic [4:0] q,
                                      input logic [19:0] m);
      for (int i = 1; i <= 20; i++)
         if (m[(q + i) % 20]) return 5'((q + i) % 20);
      return q;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic fr(input logic [6:0] a, input logic rw, input int n);
      host.frame(a, rw, n);
      tick(1);
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      host.wr_q[0] = d;
      fr(a, 1'h0, 1);
   endtask
   task automatic rdc(input logic [6:0] a, input logic [15:0] e);
      fr(a, 1'h1, 1);
      chk({16'h0, host.rd_q[0]}, {16'h0, e});
   endtask
   task automatic dchk(input logic [4:0] q, input logic [15:0] d);
      logic [20:0] g;
      g = 21'hx;
      if (wq.size() > 0) g = wq.pop_front();
      chk({11'h0, g}, {11'h0, q, d});
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      {sys_rst, adc_conv_done, adc_sweep_done, io_supply_low} = 4'h8;
      {die_temp_alarm, remote_temp1_alarm, remote_temp2_alarm} = 9'h0;
      {dac_port_mask, adc_port_mask, adc_refresh, gpi_in} = 80'h0;
      overload_in = 20'h0;
      v = $urandom(64404);
      for (int i = 0; i < 8; i++) adc_data = {adc_data[207:0], $urandom};
      temp_int_data = 12'($urandom);
      temp_ext1_data = 12'($urandom);
      temp_ext2_data = 12'($urandom);
      tick(4);
      sys_rst = 1'h0;
      tick(4);
      wr(A_CTL, 16'h4000);
      chk({16'h0, dev_ctl}, 32'h4000);
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         host.wr_q[0] = v[15:0];
         host.wr_q[1] = {12'h0, v[19:16]};
         fr(A_GPO_LO, 1'h0, 2);
         chk({12'h0, gpo_out}, {12'h0, v[19:0]});
         fr(A_GPO_LO, 1'h1, 3);
         chk({host.rd_q[1], host.rd_q[0]}, {12'h0, v[19:0]});
         chk({16'h0, host.rd_q[2]}, 32'h0);
      end
      wr(A_ID, ~ID_V);
      rdc(A_ID, ID_V);
      wr(A_TMP_INT, 16'hffff);
      rdc(A_TMP_INT, {4'h0, temp_int_data});
      $display("test access complete");
      dac_port_mask = ($urandom & 20'h88421) | 20'h00020;
      p = nxt(5'h13, dac_port_mask);
      for (int k = 0; k < 6; k++) host.wr_q[k] = 16'($urandom);
      fr(A_DAC_BASE + 7'(p), 1'h0, 6);
      for (int k = 0; k < 6; k++) begin
         dchk(p, host.wr_q[k]);
         p = nxt(p, dac_port_mask);
      end
      adc_port_mask = dac_port_mask ^ 20'h11111;
      p = nxt(5'h13, adc_port_mask);
      fr(A_ADC_BASE + 7'(p), 1'h1, 4);
      for (int k = 0; k < 4; k++) begin
         chk({16'h0, host.rd_q[k]}, {20'h0, adc_data[p*12 +: 12]});
         p = nxt(p, adc_port_mask);
      end
      wr(A_CTL, {14'h0, ADC_CONV});
      for (int k = 0; k < 3; k++) host.wr_q[k] = 16'($urandom);
      fr(7'h72, 1'h0, 3);
      dchk(5'h12, host.wr_q[0]);
      dchk(5'h13, host.wr_q[1]);
      dchk(5'h13, host.wr_q[2]);
      $display("test burst complete");
      wr(A_MASK, 16'h0000);
      chk({31'h0, irq_n}, 32'h1);
      adc_conv_done = 1'h1;
      tick(1);
      adc_conv_done = 1'h0;
      tick(3);
      chk({31'h0, irq_n}, 32'h0);
      rdc(A_INT, 16'h0001);
      chk({31'h0, irq_n}, 32'h1);
      repeat (2) begin
         adc_refresh = 20'h00008;
         tick(1);
         adc_refresh = 20'h0;
         tick(2);
      end
      rdc(A_INT, 16'h0006);
      chk({31'h0, irq_n}, 32'h0);
      rdc(A_ADCST_LO, 16'h0008);
      rdc(A_ADCST_HI, 16'h0000);
      chk({31'h0, irq_n}, 32'h1);
      wr(A_GMODE0, {14'h0, GM_RISE});
      gpi_in = 20'h00003;
      tick(8);
      rdc(A_INT, 16'h0008);
      rdc(A_GPIST_LO, 16'h0001);
      rdc(A_GPIST_HI, 16'h0000);
      chk({31'h0, irq_n}, 32'h1);
      wr(A_GMODE0, {14'h0, GM_BOTH});
      gpi_in = 20'h00002;
      tick(8);
      gpi_in = 20'h00003;
      tick(8);
      rdc(A_INT, 16'h0018);
      rdc(A_GPIST_LO, 16'h0001);
      rdc(A_GPIST_HI, 16'h0000);
      chk({31'h0, irq_n}, 32'h1);
      for (int i = 0; i < 3; i++) begin
         die_temp_alarm = 3'(1 << i);
         tick(1);
         die_temp_alarm = 3'h0;
         tick(3);
         rdc(A_INT, 16'h0040 << i);
      end
      $display("test flags complete");
      sys_rst = 1'h1;
      tick(2);
      sys_rst = 1'h0;
      tick(3);
      chk({12'h0, gpo_out}, 32'h0);
      wr(A_CTL, {14'h0, ADC_CONV});
      adc_conv_done = 1'h1;
      tick(1);
      adc_conv_done = 1'h0;
      tick(4);
      chk({31'h0, irq_n}, 32'h1);
      $display("test reset complete");
      end_of_test();
   end
endmodule
`default_nettype wire
